// >>> design/pms_pkg.sv
// Contract
// - power-up enters full-on, pll on unbypassed
// - active: pll enabled but bypassed (code: bypassed, pll enable follows the pll_en bit)
// - multiplier change pends until full-on entry
// - sleep stops core clock, system clock runs
// - sleep wake: bypass clear full-on, else active
// - sleep blocks system dma to l1
// - deep sleep stops clocks; reset/rtc exit
// - deep sleep rtc interrupt goes active
// - deep sleep reset goes full-on
// - deep sleep blocks async peripheral accesses
// - regulator frequency zero enters hibernate
// - hibernate tristates external pins
// - listed wake events restore core supply
// - hibernate exit runs full reset sequence
// - hibernate keeps only regulator/rtc registers
// - transceiver preamble/interrupt wakes from sleep
// - transceiver activity wakes sleep and hibernate
package pms_pkg;
  localparam logic [11:0] PMS_PLL_CONTROL_REG_ADDR = 12'h000;
  localparam logic [11:0] PMS_REG_CTL_ADDR = 12'h004;
  localparam logic [11:0] PMS_STATUS_ADDR = 12'h008;
  // pll control field positions
  localparam int PMS_PLL_EN_BIT = 0;
  localparam int PMS_BYPASS_BIT = 1;
  localparam int PMS_SLEEP_BIT = 2;
  localparam int PMS_DEEP_BIT = 3;
  localparam int PMS_MULT_LSB = 8;
  localparam int PMS_MULT_W = 6;
  localparam logic [5:0] PMS_MULT_RST = 6'h08;
  // regulator control: frequency field in bits 1:0
  localparam int PMS_REGULATOR_FREQUENCY_FIELD_W = 2;
  localparam logic [1:0] PMS_REGULATOR_FREQUENCY_FIELD_OFF = 2'h0;
  localparam logic [1:0] PMS_REGULATOR_FREQUENCY_FIELD_RST = 2'h3;
  localparam int PMS_WAKE_W = 8;
  localparam int PMS_WAKE_LSB = 8;
  localparam logic [7:0] PMS_WAKE_EN_RST = 8'hFF;
  // hibernate exit reset sequence length
  localparam logic [3:0] PMS_RST_SEQ_CYC = 4'hF;
  typedef enum logic [2:0] {
    PMS_FULL_ON,
    PMS_ACTIVE,
    PMS_SLEEP,
    PMS_DEEP_SLEEP,
    PMS_HIBERNATE,
    PMS_RESET_SEQ
  } pms_mode_e;
  typedef struct packed {
    logic core_clk_en;
    logic sys_clk_en;
    logic pll_en;
    logic pll_bypass;
    logic core_supply_on;
    logic dma_l1_block;
    logic async_block;
    logic pins_tristate;
  } pms_ctl_s;
endpackage

// >>> design/pms_wake_merge.sv
`timescale 1ns/1ps
`default_nettype none
// combines wake sources into sleep and hibernate wake pulses
module pms_wake_merge (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // sources: can, xcvr, keypad, updown, usb, gpio, rtc, xcvr activity
  input wire logic [7:0] i_src,
  input wire logic [7:0] i_enable,
  // xcvr preamble and interrupt events
  input wire logic i_xcvr_preamble,
  input wire logic i_xcvr_irq,
  // wake outputs
  output logic o_sleep_wake,
  output logic o_hib_wake
);
  logic [7:0] gated;
  always_comb
  begin
    gated = i_src & i_enable;
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_sleep_wake <= 1'b0;
      o_hib_wake <= 1'b0;
    end
    else
    begin
      o_sleep_wake <= (|gated) | i_xcvr_preamble | i_xcvr_irq;
      o_hib_wake <= |gated;
    end
  end
endmodule
`default_nettype wire

// >>> design/pms_apb_regs.sv
`timescale 1ns/1ps
`default_nettype none
// apb slave, zero wait states
module pms_apb_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // decoded
  output logic o_wr_pll,
  output logic o_wr_reg,
  input wire logic [31:0] i_pll_rd,
  input wire logic [31:0] i_reg_rd,
  input wire logic [31:0] i_status_rd
);
  logic acc;
  logic setup;
  logic hit;
  logic [31:0] rd_mux;
  always_comb
  begin
    acc = i_psel & i_penable & o_pready;
    setup = i_psel & ~i_penable;
    hit = (i_paddr == pms_pkg::PMS_PLL_CONTROL_REG_ADDR) | (i_paddr == pms_pkg::PMS_REG_CTL_ADDR)
      | (i_paddr == pms_pkg::PMS_STATUS_ADDR);
    o_wr_pll = acc & i_pwrite & (i_paddr == pms_pkg::PMS_PLL_CONTROL_REG_ADDR);
    o_wr_reg = acc & i_pwrite & (i_paddr == pms_pkg::PMS_REG_CTL_ADDR);
    unique case (i_paddr)
      pms_pkg::PMS_PLL_CONTROL_REG_ADDR: rd_mux = i_pll_rd;
      pms_pkg::PMS_REG_CTL_ADDR: rd_mux = i_reg_rd;
      pms_pkg::PMS_STATUS_ADDR: rd_mux = i_status_rd;
      default: rd_mux = 32'h00000000;
    endcase
  end
  // answer registered in the setup cycle, so the access phase still has no wait
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else if (setup)
    begin
      o_prdata <= rd_mux;
      o_pready <= 1'b1;
      o_pslverr <= ~hit;
    end
    else
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> design/pms_sequencer.sv
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pms_sequencer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // core and wake inputs
  input wire logic i_core_idle,
  input wire logic i_reset_pin,
  input wire logic i_rtc_irq,
  input wire logic [7:0] i_wake_src,
  input wire logic i_xcvr_preamble,
  input wire logic i_xcvr_irq,
  // mode outputs
  output pms_pkg::pms_ctl_s o_ctl,
  output logic [5:0] o_mult,
  output logic o_sys_reset
);
  pms_pkg::pms_mode_e mode;
  logic pll_en, bypass, sleep_req, deep_req;
  logic [5:0] mult_pend;
  logic [1:0] regulator_frequency_field;
  logic [7:0] wake_en;
  logic [3:0] seq_cnt;
  logic wr_pll, wr_reg, sleep_wake, hib_wake;
  logic [31:0] pll_rd, reg_rd, st_rd;

  pms_apb_regs u_regs (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_wr_pll(wr_pll),
    .o_wr_reg(wr_reg),
    .i_pll_rd(pll_rd),
    .i_reg_rd(reg_rd),
    .i_status_rd(st_rd)
  );

  pms_wake_merge u_wake (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_src(i_wake_src),
    .i_enable(wake_en),
    .i_xcvr_preamble(i_xcvr_preamble),
    .i_xcvr_irq(i_xcvr_irq),
    .o_sleep_wake(sleep_wake),
    .o_hib_wake(hib_wake)
  );

  always_comb
  begin
    pll_rd = 32'h00000000;
    pll_rd[pms_pkg::PMS_PLL_EN_BIT] = pll_en;
    pll_rd[pms_pkg::PMS_BYPASS_BIT] = bypass;
    pll_rd[pms_pkg::PMS_SLEEP_BIT] = sleep_req;
    pll_rd[pms_pkg::PMS_DEEP_BIT] = deep_req;
    pll_rd[pms_pkg::PMS_MULT_LSB +: pms_pkg::PMS_MULT_W] = mult_pend;
    reg_rd = {16'h0000, wake_en, 6'h00, regulator_frequency_field};
    st_rd = {23'h000000, o_mult, mode};
  end

  // regulator control register; wake enables retained across hibernate, frequency field restored on exit
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      regulator_frequency_field <= pms_pkg::PMS_REGULATOR_FREQUENCY_FIELD_RST;
      wake_en <= pms_pkg::PMS_WAKE_EN_RST;
    end
    else if (wr_reg)
    begin
      regulator_frequency_field <= i_pwdata[pms_pkg::PMS_REGULATOR_FREQUENCY_FIELD_W-1:0];
      wake_en <= i_pwdata[pms_pkg::PMS_WAKE_LSB +: pms_pkg::PMS_WAKE_W];
    end
    else if (mode == pms_pkg::PMS_HIBERNATE && (hib_wake || i_reset_pin))
      regulator_frequency_field <= pms_pkg::PMS_REGULATOR_FREQUENCY_FIELD_RST;
  end

  // pll control; reloaded with power-up values by hibernate exit sequence
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pll_en <= 1'b1;
      bypass <= 1'b0;
      sleep_req <= 1'b0;
      deep_req <= 1'b0;
      mult_pend <= pms_pkg::PMS_MULT_RST;
    end
    else if (mode == pms_pkg::PMS_RESET_SEQ)
    begin
      pll_en <= 1'b1;
      bypass <= 1'b0;
      sleep_req <= 1'b0;
      deep_req <= 1'b0;
      mult_pend <= pms_pkg::PMS_MULT_RST;
    end
    else if (wr_pll)
    begin
      pll_en <= i_pwdata[pms_pkg::PMS_PLL_EN_BIT];
      bypass <= i_pwdata[pms_pkg::PMS_BYPASS_BIT];
      sleep_req <= i_pwdata[pms_pkg::PMS_SLEEP_BIT];
      deep_req <= i_pwdata[pms_pkg::PMS_DEEP_BIT];
      mult_pend <= i_pwdata[pms_pkg::PMS_MULT_LSB +: pms_pkg::PMS_MULT_W];
    end
    else if (i_core_idle && mode inside {pms_pkg::PMS_FULL_ON, pms_pkg::PMS_ACTIVE})
    begin
      sleep_req <= 1'b0;
      deep_req <= 1'b0;
    end
  end

  // mode machine
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mode <= pms_pkg::PMS_FULL_ON;
      seq_cnt <= 4'h0;
    end
    else
    begin
      unique case (mode)
        pms_pkg::PMS_FULL_ON, pms_pkg::PMS_ACTIVE:
        begin
          if (regulator_frequency_field == pms_pkg::PMS_REGULATOR_FREQUENCY_FIELD_OFF)
            mode <= pms_pkg::PMS_HIBERNATE;
          else if (i_core_idle && deep_req)
            mode <= pms_pkg::PMS_DEEP_SLEEP;
          else if (i_core_idle && sleep_req)
            mode <= pms_pkg::PMS_SLEEP;
          else if (bypass)
            mode <= pms_pkg::PMS_ACTIVE;
          else if (pll_en)
            mode <= pms_pkg::PMS_FULL_ON;
        end
        pms_pkg::PMS_SLEEP:
          if (sleep_wake)
            mode <= bypass ? pms_pkg::PMS_ACTIVE : pms_pkg::PMS_FULL_ON;
        pms_pkg::PMS_DEEP_SLEEP:
          if (i_reset_pin)
            mode <= pms_pkg::PMS_FULL_ON;
          else if (i_rtc_irq)
            mode <= pms_pkg::PMS_ACTIVE;
        pms_pkg::PMS_HIBERNATE:
          if (hib_wake || i_reset_pin)
          begin
            mode <= pms_pkg::PMS_RESET_SEQ;
            seq_cnt <= 4'h0;
          end
        pms_pkg::PMS_RESET_SEQ:
          if (seq_cnt == pms_pkg::PMS_RST_SEQ_CYC)
            mode <= pms_pkg::PMS_FULL_ON;
          else
            seq_cnt <= seq_cnt + 4'h1;
        default:
          mode <= pms_pkg::PMS_FULL_ON;
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_ctl <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      o_mult <= pms_pkg::PMS_MULT_RST;
      o_sys_reset <= 1'b0;
    end
    else
    begin
      o_ctl.core_clk_en <= mode inside {pms_pkg::PMS_FULL_ON, pms_pkg::PMS_ACTIVE};
      o_ctl.sys_clk_en <= mode inside {pms_pkg::PMS_FULL_ON, pms_pkg::PMS_ACTIVE,
        pms_pkg::PMS_SLEEP};
      o_ctl.pll_en <= (mode == pms_pkg::PMS_ACTIVE) ? pll_en
        : mode inside {pms_pkg::PMS_FULL_ON, pms_pkg::PMS_SLEEP};
      o_ctl.pll_bypass <= (mode == pms_pkg::PMS_ACTIVE);
      o_ctl.core_supply_on <= !(mode inside {pms_pkg::PMS_HIBERNATE});
      o_ctl.dma_l1_block <= (mode == pms_pkg::PMS_SLEEP);
      o_ctl.async_block <= (mode == pms_pkg::PMS_DEEP_SLEEP);
      o_ctl.pins_tristate <= (mode == pms_pkg::PMS_HIBERNATE);
      o_sys_reset <= (mode == pms_pkg::PMS_RESET_SEQ);
      if (mode == pms_pkg::PMS_FULL_ON)
        o_mult <= mult_pend;
    end
  end

  property p_sleep_clocks;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_SLEEP |=> !o_ctl.core_clk_en && o_ctl.sys_clk_en;
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks) else $error("sleep clocks wrong");
  property p_sleep_wake;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_SLEEP && sleep_wake && !bypass |=> mode == pms_pkg::PMS_FULL_ON;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake mode wrong");
  property p_deep_rtc;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_DEEP_SLEEP && i_rtc_irq && !i_reset_pin
      |=> mode == pms_pkg::PMS_ACTIVE;
  endproperty
  a_deep_rtc: assert property (p_deep_rtc) else $error("rtc wake failed");
  property p_deep_rst;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_DEEP_SLEEP && i_reset_pin |=> mode == pms_pkg::PMS_FULL_ON;
  endproperty
  a_deep_rst: assert property (p_deep_rst) else $error("reset wake failed");
  property p_hib_enter;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_HIBERNATE |=> !o_ctl.core_supply_on && o_ctl.pins_tristate;
  endproperty
  a_hib_enter: assert property (p_hib_enter) else $error("hibernate outputs wrong");
  property p_hib_exit;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_HIBERNATE && hib_wake |=> mode == pms_pkg::PMS_RESET_SEQ ##1 o_sys_reset;
  endproperty
  a_hib_exit: assert property (p_hib_exit) else $error("no reset sequence");
  property p_active_bypass;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_ACTIVE |=> o_ctl.pll_bypass && o_mult == $past(o_mult);
  endproperty
  a_active_bypass: assert property (p_active_bypass) else $error("active bypass wrong");
  property p_deep_block;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_DEEP_SLEEP |=> o_ctl.async_block && !o_ctl.sys_clk_en;
  endproperty
  a_deep_block: assert property (p_deep_block) else $error("deep sleep block wrong");
  property p_full_on;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_FULL_ON |=> o_ctl.pll_en && !o_ctl.pll_bypass && o_ctl.core_clk_en;
  endproperty
  a_full_on: assert property (p_full_on) else $error("full-on controls wrong");
  property p_mult_hold;
    @(posedge i_clk) disable iff (!i_rstn)
    mode != pms_pkg::PMS_FULL_ON |=> o_mult == $past(o_mult);
  endproperty
  a_mult_hold: assert property (p_mult_hold) else $error("multiplier changed early");
  property p_mult_load;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_FULL_ON |=> o_mult == $past(mult_pend);
  endproperty
  a_mult_load: assert property (p_mult_load) else $error("multiplier not loaded");
  property p_sleep_dma;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_SLEEP |=> o_ctl.dma_l1_block;
  endproperty
  a_sleep_dma: assert property (p_sleep_dma) else $error("sleep dma not blocked");
  property p_idle_wait;
    @(posedge i_clk) disable iff (!i_rstn)
    mode inside {pms_pkg::PMS_FULL_ON, pms_pkg::PMS_ACTIVE} && !i_core_idle
      |=> mode inside {pms_pkg::PMS_FULL_ON, pms_pkg::PMS_ACTIVE, pms_pkg::PMS_HIBERNATE};
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("mode left before idle");
  property p_xcvr_wake;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_SLEEP && (i_xcvr_preamble || i_xcvr_irq)
      |=> sleep_wake ##1 mode != pms_pkg::PMS_SLEEP;
  endproperty
  a_xcvr_wake: assert property (p_xcvr_wake) else $error("transceiver wake lost");
  property p_hib_src;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_HIBERNATE && ((i_wake_src & wake_en) != 8'h00)
      |-> ##2 mode == pms_pkg::PMS_RESET_SEQ;
  endproperty
  a_hib_src: assert property (p_hib_src) else $error("hibernate wake lost");
  property p_hib_regulator_frequency_field;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_HIBERNATE && (hib_wake || i_reset_pin) && !wr_reg
      |=> regulator_frequency_field == pms_pkg::PMS_REGULATOR_FREQUENCY_FIELD_RST;
  endproperty
  a_hib_regulator_frequency_field: assert property (p_hib_regulator_frequency_field) else $error("regulator not restored");
  property p_seq_regs;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_RESET_SEQ
      |=> pll_en && !bypass && mult_pend == pms_pkg::PMS_MULT_RST;
  endproperty
  a_seq_regs: assert property (p_seq_regs) else $error("pll control not reset");
  property p_seq_done;
    @(posedge i_clk) disable iff (!i_rstn)
    mode == pms_pkg::PMS_RESET_SEQ && seq_cnt == pms_pkg::PMS_RST_SEQ_CYC
      |=> mode == pms_pkg::PMS_FULL_ON && o_sys_reset;
  endproperty
  a_seq_done: assert property (p_seq_done) else $error("reset sequence end wrong");
  c_sleep: cover property (@(posedge i_clk) mode == pms_pkg::PMS_SLEEP);
  c_active: cover property (@(posedge i_clk) mode == pms_pkg::PMS_ACTIVE);
  c_seq_end: cover property (@(posedge i_clk) o_sys_reset ##1 !o_sys_reset);
  c_deep: cover property (@(posedge i_clk) mode == pms_pkg::PMS_DEEP_SLEEP);
  c_hib: cover property (@(posedge i_clk) mode == pms_pkg::PMS_RESET_SEQ);
endmodule
`default_nettype wire

// >>> testbench/pms_wake_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side wake sources and reset pin
module pms_wake_model (
  // clock
  input wire logic i_clk,
  // events
  output logic [7:0] o_src,
  output logic o_rtc_irq,
  output logic o_reset_pin,
  output logic o_preamble,
  output logic o_xcvr_irq
);
  logic [11:0] ev;
  assign o_src = ev[7:0];
  assign o_rtc_irq = ev[8];
  assign o_reset_pin = ev[9];
  assign o_preamble = ev[10];
  assign o_xcvr_irq = ev[11];
  initial
  begin
    ev = 12'h000;
  end
  // one event line high for three cycles
  task automatic pulse(input int idx);
    @(posedge i_clk);
    ev[idx] <= 1'b1;
    repeat (3) @(posedge i_clk);
    ev <= 12'h000;
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [11:0] A_PLL = pms_pkg::PMS_PLL_CONTROL_REG_ADDR;
  localparam logic [11:0] A_REG = pms_pkg::PMS_REG_CTL_ADDR;
  localparam logic [11:0] A_ST = pms_pkg::PMS_STATUS_ADDR;
  logic i_clk = 1'b0;
  logic i_rstn, psel, penable, pwrite, idle, rtc, rpin, pre, xirq, pready, pslverr, sys_rst, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [7:0] src;
  logic [5:0] mult;
  pms_pkg::pms_ctl_s ctl;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2 i_clk = ~i_clk;
  pms_sequencer pms_sequencer_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_core_idle(idle),
    .i_reset_pin(rpin), .i_rtc_irq(rtc), .i_wake_src(src), .i_xcvr_preamble(pre),
    .i_xcvr_irq(xirq), .o_ctl(ctl), .o_mult(mult), .o_sys_reset(sys_rst));
  pms_wake_model pms_wake_model_inst (.i_clk(i_clk), .o_src(src), .o_rtc_irq(rtc),
    .o_reset_pin(rpin), .o_preamble(pre), .o_xcvr_irq(xirq));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll status until the mode shows, then let o_ctl follow
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    apb(1'b0, A_ST, 32'h0);
    while (rq[2:0] !== m && n < 40)
    begin
      n++;
      apb(1'b0, A_ST, 32'h0);
    end
    chk("mode", {29'h0, rq[2:0]}, {29'h0, m});
    @(posedge i_clk);
    #1;
  endtask
  task automatic t_reset();
    #1;
    chk("ctl", {24'h0, ctl}, 32'hE8);
    chk("mult", {26'h0, mult}, 32'h8);
    apb(1'b0, A_PLL, 32'h0);
    chk("pll_control_reg", rq, 32'h801);
    apb(1'b0, A_REG, 32'h0);
    chk("reg_ctl", rq, 32'hFF03);
    apb(1'b0, A_ST, 32'h0);
    chk("status", rq, 32'h40);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", {rq[30:0], re}, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_active();
    apb(1'b1, A_PLL, 32'h0803);
    wait_mode(3'h1);
    chk("ctl", {24'h0, ctl}, 32'hF8);
    apb(1'b1, A_PLL, 32'h1003);
    apb(1'b0, A_PLL, 32'h0);
    chk("pll_control_reg", rq, 32'h1003);
    chk("mult", {26'h0, mult}, 32'h8);
    apb(1'b1, A_PLL, 32'h1001);
    wait_mode(3'h0);
    chk("mult", {26'h0, mult}, 32'h10);
    $display("test active done");
  endtask
  task automatic t_sleep();
    logic [31:0] cmd [3] = '{32'h1005, 32'h1007, 32'h1005};
    int ev [3] = '{10, 7, 11};
    logic [2:0] back [3] = '{3'h0, 3'h1, 3'h0};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, A_PLL, cmd[i]);
      wait_mode(3'h2);
      chk("core_clk", {31'h0, ctl.core_clk_en}, 32'h0);
      chk("sys_clk", {31'h0, ctl.sys_clk_en}, 32'h1);
      chk("dma_block", {31'h0, ctl.dma_l1_block}, 32'h1);
      pms_wake_model_inst.pulse(ev[i]);
      wait_mode(back[i]);
    end
    $display("test sleep done");
  endtask
  task automatic t_deep();
    @(posedge i_clk);
    idle <= 1'b0;
    apb(1'b1, A_PLL, 32'h1009);
    repeat (8) @(posedge i_clk);
    apb(1'b0, A_ST, 32'h0);
    chk("mode_busy", {29'h0, rq[2:0]}, 32'h0);
    // bypass set so the rtc wake settles in active
    apb(1'b1, A_PLL, 32'h100B);
    idle <= 1'b1;
    wait_mode(3'h3);
    chk("core_clk", {31'h0, ctl.core_clk_en}, 32'h0);
    chk("sys_clk", {31'h0, ctl.sys_clk_en}, 32'h0);
    chk("async_block", {31'h0, ctl.async_block}, 32'h1);
    pms_wake_model_inst.pulse(8);
    wait_mode(3'h1);
    apb(1'b1, A_PLL, 32'h1009);
    wait_mode(3'h3);
    pms_wake_model_inst.pulse(9);
    wait_mode(3'h0);
    $display("test deep done");
  endtask
  task automatic t_hib();
    // nothing worth keeping in this run
    apb(1'b1, A_REG, 32'h8000);
    wait_mode(3'h4);
    chk("supply", {31'h0, ctl.core_supply_on}, 32'h0);
    chk("clocks", {30'h0, ctl.core_clk_en, ctl.sys_clk_en}, 32'h0);
    chk("tristate", {31'h0, ctl.pins_tristate}, 32'h1);
    pms_wake_model_inst.pulse(7);
    wait_mode(3'h5);
    chk("sys_reset", {31'h0, sys_rst}, 32'h1);
    wait_mode(3'h0);
    chk("ctl", {24'h0, ctl}, 32'hE8);
    chk("sys_reset", {31'h0, sys_rst}, 32'h0);
    apb(1'b0, A_REG, 32'h0);
    chk("reg_ctl", rq, 32'h8003);
    apb(1'b0, A_PLL, 32'h0);
    chk("pll_control_reg", rq, 32'h801);
    apb(1'b1, A_REG, 32'h8000);
    wait_mode(3'h4);
    pms_wake_model_inst.pulse(9);
    wait_mode(3'h0);
    apb(1'b0, A_REG, 32'h0);
    chk("reg_ctl", rq, 32'h8003);
    $display("test hibernate done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      results();
    end
  end
  initial
  begin
    i_rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    idle = 1'b1;
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset();
    t_active();
    t_sleep();
    t_deep();
    t_hib();
    results();
  end
endmodule
`default_nettype wire
